// ===== verilog/current_calc_alert_control.sv
// current calculation, limit comparison and alert pin control
// Overview of operation
// - current is shunt times scale value
// - scale register 15 bits, top zero, reset 0
// - scale value sets current and power step
// - highest enabled limit source wins
// - shunt above limit raises alert
// - shunt below limit raises alert
// - bus above limit raises alert
// - bus below limit raises alert
// - power above limit raises alert
// - done flag may raise alert too
// - limit flag shows limit caused alert
// - control resets zero, unused bits read zero
// - latch holds until read, else follows
// - done flag set, cleared in single-shot
// - bit1 pin polarity, bit0 latch select
// - overflow flag marks invalid results
`timescale 1ns/1ns
`default_nettype none
module current_calc_alert_control (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire alert_calc_pkg::reg_req_t req,
  output logic [15:0] rd_data,
  input wire alert_calc_pkg::conv_t conv,
  input wire logic [15:0] alert_limit,
  input wire logic single_shot,
  input wire logic cfg_write,
  input wire logic cfg_powerdown,
  output logic [15:0] power_result,
  output logic alert_out,
  output logic alert_oe_n
);
  import alert_calc_pkg::*;

  logic [14:0] scale_r;
  logic [5:0] enables_r;
  logic [1:0] mode_r;
  logic limit_alert_flag_r, conversion_done_flag_r, math_overflow_flag_r;
  logic [15:0] current_r, shunt_r, bus_r, power_r, rd_data_r;
  logic st1_r, shunt_new_r, bus_new_r, cur_overflow_r;
  logic alert_oe_n_r, alert_out_r;

  wire wr_scale = req.wr && req.addr == SCALE_OFFSET;
  wire wr_ctl = req.wr && req.addr == CONTROL_OFFSET;
  wire rd_ctl = req.rd && req.addr == CONTROL_OFFSET;
  wire latch_mode = mode_r[LATCH_SELECT_BIT];
  wire active_high = mode_r[ACTIVE_LEVEL_BIT];

  wire signed [31:0] cur_prod = $signed(conv.shunt) * $signed({17'h0_0000, scale_r});
  wire signed [31:0] cur_shift = cur_prod >>> CURRENT_SHIFT;
  wire cur_overflow = !(&cur_shift[31:15] || ~|cur_shift[31:15]);
  wire [15:0] cur_abs = current_r[15] ? 16'(-current_r) : current_r;
  wire [31:0] pow_prod = cur_abs * bus_r;
  wire [31:0] pow_shift = pow_prod >> POWER_SHIFT;
  wire pow_overflow = |pow_shift[31:16];

  limit_sel_t sel;
  assign sel = enables_r[5] ? SEL_SHUNT_OVER :
               enables_r[4] ? SEL_SHUNT_UNDER :
               enables_r[3] ? SEL_BUS_OVER :
               enables_r[2] ? SEL_BUS_UNDER :
               enables_r[1] ? SEL_POWER_OVER : SEL_NONE;

  // signed shunt compare, unsigned bus and power
  wire shunt_gt = $signed(shunt_r) > $signed(alert_limit);
  wire shunt_lt = $signed(shunt_r) < $signed(alert_limit);
  wire bus_gt = bus_r > alert_limit;
  wire bus_lt = bus_r < alert_limit;
  wire pow_gt = pow_shift[15:0] > alert_limit;
  wire fault = sel == SEL_SHUNT_OVER ? shunt_gt :
               sel == SEL_SHUNT_UNDER ? shunt_lt :
               sel == SEL_BUS_OVER ? bus_gt :
               sel == SEL_BUS_UNDER ? bus_lt :
               sel == SEL_POWER_OVER ? pow_gt : 1'b0;
  wire eval = st1_r && (sel == SEL_POWER_OVER ||
              ((sel == SEL_SHUNT_OVER || sel == SEL_SHUNT_UNDER) && shunt_new_r) ||
              ((sel == SEL_BUS_OVER || sel == SEL_BUS_UNDER) && bus_new_r));

  // latch holds until read, transparent follows
  wire limit_alert_flag_nxt = eval ? (fault || (latch_mode && limit_alert_flag_r)) :
                              (latch_mode && rd_ctl) ? 1'b0 : limit_alert_flag_r;
  wire done_flag_clr = single_shot && ((cfg_write && !cfg_powerdown) || rd_ctl);
  wire conversion_done_flag_nxt = st1_r ? 1'b1 :
                                  done_flag_clr ? 1'b0 : conversion_done_flag_r;
  // alert from limit flag or done flag
  wire asserted = limit_alert_flag_r || (enables_r[0] && conversion_done_flag_r);
  // open-drain pin pulled low per polarity
  wire pin_low_nxt = active_high ? !asserted : asserted;

  wire [15:0] ctl_view = {enables_r, 5'h00, limit_alert_flag_r, conversion_done_flag_r,
                          math_overflow_flag_r, mode_r};
  wire [15:0] rd_nxt = req.addr == CURRENT_OFFSET ? current_r :
                       req.addr == SCALE_OFFSET ? {1'b0, scale_r} :
                       req.addr == CONTROL_OFFSET ? ctl_view : 16'h0000;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scale_r <= SCALE_RESET[14:0];
      enables_r <= CONTROL_RESET[15:10];
      mode_r <= CONTROL_RESET[1:0];
    end else begin
      if (wr_scale) begin
        scale_r <= req.wdata[14:0];
      end
      if (wr_ctl) begin
        enables_r <= req.wdata[15:10];
        mode_r <= req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st1_r <= 1'b0;
      shunt_new_r <= 1'b0;
      bus_new_r <= 1'b0;
      cur_overflow_r <= 1'b0;
      current_r <= 16'h0000;
      shunt_r <= 16'h0000;
      bus_r <= 16'h0000;
    end else begin
      st1_r <= conv.valid;
      shunt_new_r <= conv.valid && conv.shunt_new;
      bus_new_r <= conv.valid && conv.bus_new;
      if (conv.valid && conv.shunt_new) begin
        current_r <= cur_shift[15:0];
        cur_overflow_r <= cur_overflow;
        shunt_r <= conv.shunt;
      end
      if (conv.valid && conv.bus_new) begin
        bus_r <= conv.bus;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_r <= 16'h0000;
      math_overflow_flag_r <= 1'b0;
      limit_alert_flag_r <= 1'b0;
      conversion_done_flag_r <= 1'b0;
      alert_oe_n_r <= 1'b1;
      alert_out_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      if (st1_r) begin
        power_r <= pow_shift[15:0];
        math_overflow_flag_r <= cur_overflow_r || pow_overflow;
      end
      limit_alert_flag_r <= limit_alert_flag_nxt;
      conversion_done_flag_r <= conversion_done_flag_nxt;
      alert_oe_n_r <= !pin_low_nxt;
      alert_out_r <= 1'b0;
      if (req.rd) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  assign rd_data = rd_data_r;
  assign power_result = power_r;
  assign alert_out = alert_out_r;
  assign alert_oe_n = alert_oe_n_r;

  sequence s_ctl_read;
    rd_ctl && !eval;
  endsequence

  sequence s_conv_in;
    conv.valid && conv.shunt_new;
  endsequence

  sequence s_flag_up;
    limit_alert_flag_r && !wr_ctl;
  endsequence

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_scale_top_zero: assert property (req.rd && req.addr == SCALE_OFFSET |=> !rd_data[15])
    else $error("scale top bit read as one");
  a_scale_write: assert property (wr_scale |=> scale_r == $past(req.wdata[14:0]))
    else $error("scale value not written");
  a_current_product: assert property (s_conv_in |=> current_r == 16'($past(cur_shift)))
    else $error("current result not shunt times scale");
  a_ctl_reserved: assert property (req.rd && req.addr == CONTROL_OFFSET
    |=> rd_data[9:5] == 5'h00)
    else $error("unused control bits not zero");
  a_shunt_over: assert property (eval && sel == SEL_SHUNT_OVER && shunt_gt
    |=> limit_alert_flag_r)
    else $error("shunt over limit missed");
  a_bus_under: assert property (eval && sel == SEL_BUS_UNDER && bus_lt |=> limit_alert_flag_r)
    else $error("bus under limit missed");
  a_transparent_clear: assert property (eval && !latch_mode && !fault
    |=> !limit_alert_flag_r)
    else $error("transparent flag not cleared");
  a_latch_hold: assert property (latch_mode && limit_alert_flag_r && !(rd_ctl && !eval)
    |=> limit_alert_flag_r)
    else $error("latched flag dropped without read");
  a_latch_clear: assert property (s_ctl_read ##0 latch_mode |=> !limit_alert_flag_r)
    else $error("latched flag not cleared by read");
  a_done_set: assert property (s_conv_in |-> ##2 conversion_done_flag_r)
    else $error("done flag not set after conversion");
  a_done_clear: assert property (!st1_r && done_flag_clr |=> !conversion_done_flag_r)
    else $error("done flag not cleared");
  a_done_set_wins: assert property (st1_r && done_flag_clr |=> conversion_done_flag_r)
    else $error("done flag clear beat set");
  a_pin_level: assert property (enables_r[0] && conversion_done_flag_r && !wr_ctl
    |=> alert_oe_n == active_high)
    else $error("alert pin level wrong for done alert");
  a_flag_pin: assert property (s_flag_up |=> alert_oe_n == active_high)
    else $error("alert pin level wrong for limit alert");
  a_power_overflow: assert property (st1_r && pow_overflow |=> math_overflow_flag_r)
    else $error("overflow flag not set");
  a_current_overflow: assert property (s_conv_in ##0 cur_overflow
    |-> ##2 math_overflow_flag_r)
    else $error("current overflow not flagged");
endmodule
`default_nettype wire

// ===== verilog/alert_calc_pkg.sv
// constants and carriers for the current calculation and alert block
package alert_calc_pkg;
  localparam logic [7:0] CURRENT_OFFSET = 8'h04;
  localparam logic [7:0] SCALE_OFFSET = 8'h05;
  localparam logic [7:0] CONTROL_OFFSET = 8'h06;
  localparam logic [15:0] SCALE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam int SCALE_TOP_BIT = 15;
  localparam int SHUNT_OVER_BIT = 15;
  localparam int SHUNT_UNDER_BIT = 14;
  localparam int BUS_OVER_BIT = 13;
  localparam int BUS_UNDER_BIT = 12;
  localparam int POWER_OVER_BIT = 11;
  localparam int DONE_ALERT_BIT = 10;
  localparam int LIMIT_FLAG_BIT = 4;
  localparam int DONE_FLAG_BIT = 3;
  localparam int OVERFLOW_BIT = 2;
  localparam int ACTIVE_LEVEL_BIT = 1;
  localparam int LATCH_SELECT_BIT = 0;
  localparam int CURRENT_SHIFT = 11;
  localparam int POWER_SHIFT = 12;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic shunt_new;
    logic bus_new;
    logic [15:0] shunt;
    logic [15:0] bus;
  } conv_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_SHUNT_OVER = 3'b001,
    SEL_SHUNT_UNDER = 3'b010,
    SEL_BUS_OVER = 3'b011,
    SEL_BUS_UNDER = 3'b100,
    SEL_POWER_OVER = 3'b101
  } limit_sel_t;
endpackage

// ===== tb/host_model.sv
// host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output var alert_calc_pkg::reg_req_t req,
  input wire logic [15:0] rd_data
);
  import alert_calc_pkg::*;
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    #1;
    req = '0;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for current calculation and alert control
`timescale 1ns/1ns
`default_nettype none
module tb;
  import alert_calc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t req;
  conv_t conv = '0;
  logic [15:0] alert_limit = 16'h0080;
  logic single_shot = 1'b0;
  logic cfg_write = 1'b0;
  logic cfg_powerdown = 1'b0;
  logic [15:0] rd_data, power_result, v;
  logic alert_out, alert_oe_n;
  int n_fail = 0, checked = 0, cycles = 0;
  // scale, control, shunt, bus, limit, current, power, pin enable
  logic [15:0] rows [0:5][0:7] = '{
    '{16'h0800,16'h8000,16'h0100,16'h0000,16'h0080,16'h0100,16'h0000,16'h0000},
    '{16'h0800,16'h4000,16'hFF00,16'h0000,16'h0000,16'hFF00,16'h0000,16'h0000},
    '{16'h1000,16'h2000,16'h0010,16'h1000,16'h2000,16'h0020,16'h0020,16'h0001},
    '{16'h1000,16'h1000,16'h0010,16'h1000,16'h2000,16'h0020,16'h0020,16'h0000},
    '{16'h0800,16'h0800,16'h0100,16'h0100,16'h000F,16'h0100,16'h0010,16'h0000},
    '{16'h0800,16'hC000,16'h0100,16'h0000,16'h0080,16'h0100,16'h0000,16'h0000}};
  current_calc_alert_control dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .req(req),
    .rd_data(rd_data), .conv(conv), .alert_limit(alert_limit), .single_shot(single_shot),
    .cfg_write(cfg_write), .cfg_powerdown(cfg_powerdown), .power_result(power_result),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  host_model host_u (.ref_clk(ref_clk), .req(req), .rd_data(rd_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cnv(input logic [15:0] sh, input logic [15:0] bu);
    @(posedge ref_clk);
    #1;
    conv = '{valid: 1'b1, shunt_new: 1'b1, bus_new: 1'b1, shunt: sh, bus: bu};
    @(posedge ref_clk);
    #1;
    conv.valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check({15'h0000, alert_oe_n}, 16'h0001);
    host_u.rd(SCALE_OFFSET, v);
    check(v, SCALE_RESET);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, CONTROL_RESET);
    host_u.rd(8'h09, v);
    check(v, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      host_u.wr(SCALE_OFFSET, rows[i][0]);
      host_u.wr(CONTROL_OFFSET, rows[i][1]);
      alert_limit = rows[i][4];
      cnv(rows[i][2], rows[i][3]);
      check({15'h0000, alert_oe_n}, rows[i][7]);
      check(power_result, rows[i][6]);
      check({15'h0000, alert_out}, 16'h0000);
      host_u.rd(CURRENT_OFFSET, v);
      check(v, rows[i][5]);
    end
    host_u.wr(SCALE_OFFSET, 16'hFFFF);
    host_u.rd(SCALE_OFFSET, v);
    check(v, 16'h7FFF);
    single_shot = 1'b1;
    host_u.wr(CONTROL_OFFSET, 16'h81FD);
    cnv(16'h7FFF, 16'h0000);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h801D);
    cnv(16'h0100, 16'h0000);
    check({15'h0000, alert_oe_n}, 16'h0000);
    cnv(16'h0000, 16'h0000);
    check({15'h0000, alert_oe_n}, 16'h0000);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h8019);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h8001);
    check({15'h0000, alert_oe_n}, 16'h0001);
    host_u.wr(CONTROL_OFFSET, 16'h0400);
    cnv(16'h0000, 16'h0000);
    check({15'h0000, alert_oe_n}, 16'h0000);
    @(posedge ref_clk);
    #1;
    cfg_write = 1'b1;
    @(posedge ref_clk);
    #1;
    cfg_write = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({15'h0000, alert_oe_n}, 16'h0001);
    host_u.wr(CONTROL_OFFSET, 16'h0002);
    repeat (3) @(posedge ref_clk);
    #1;
    check({15'h0000, alert_oe_n}, 16'h0000);
    cnv(16'h0000, 16'h0000);
    cfg_powerdown = 1'b1;
    cfg_write = 1'b1;
    @(posedge ref_clk);
    #1;
    cfg_write = 1'b0;
    cfg_powerdown = 1'b0;
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h000A);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h0002);
    single_shot = 1'b0;
    cnv(16'h0000, 16'h0000);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h000A);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, 16'h000A);
    arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check({15'h0000, alert_oe_n}, 16'h0001);
    host_u.rd(SCALE_OFFSET, v);
    check(v, SCALE_RESET);
    host_u.rd(CONTROL_OFFSET, v);
    check(v, CONTROL_RESET);
    final_report();
  end
endmodule
`default_nettype wire
